// >>> hdl/dilc_defs.svh
`ifndef DILC_DEFS_SVH
`define DILC_DEFS_SVH

// width of the parallel input code
`define DILC_CODE_W       8
// depth of the sample fifo
`define DILC_FIFO_DEPTH   8
// edges after power-up before the output code counts as defined
`define DILC_WARMUP_EDGES 2
// width of the warm-up counter
`define DILC_WARMUP_W     2
// reset value of the held code (zero is minimum output)
`define DILC_CODE_RST     8'h00

`endif

// >>> hdl/dilc_pkg.sv
package dilc_pkg;
   // sample code as presented on the parallel pins, lsb in bit 0
   typedef logic [7:0] dilc_code_t;

   // static control pins travelling together
   typedef struct packed {
      logic power_down_pin; // high asks for standby
      logic ref_select;     // high selects the external reference
   } dilc_ctrl_t;

   // operating mode of the converter core
   typedef enum logic [1:0] {
      DILC_RUN,
      DILC_STANDBY
   } dilc_mode_t;
endpackage

// >>> hdl/dilc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "dilc_defs.svh"

// small fifo that captures the input code and feeds the conversion stage
module dilc_fifo #(
   parameter int WIDTH = `DILC_CODE_W,
   parameter int DEPTH = `DILC_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             i_core_clk,
   input  wire logic             i_rst,
   // fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // drain side
   output logic                  o_out_valid,
   output logic      [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr_ptr; // next slot to write
      logic [AW-1:0] rd_ptr; // next slot to read
      logic [AW:0]   count;  // words held
   } dilc_fifo_st_t;

   dilc_fifo_st_t    st_q;          // registered pointers
   dilc_fifo_st_t    st_d;          // next pointers
   logic [WIDTH-1:0] mem [DEPTH];   // storage array
   logic             push;          // word accepted this cycle
   logic             pop;           // word drained this cycle

   // honest flags straight from the count
   assign o_in_ready  = (st_q.count != (AW+1)'(DEPTH));
   assign o_out_valid = (st_q.count != '0);
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_out_data  = mem[st_q.rd_ptr];

   // pointer and count update
   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.wr_ptr = (st_q.wr_ptr == AW'(DEPTH-1)) ? '0 : st_q.wr_ptr + 1'b1;
      end
      if (pop) begin
         st_d.rd_ptr = (st_q.rd_ptr == AW'(DEPTH-1)) ? '0 : st_q.rd_ptr + 1'b1;
      end
      // simultaneous push and pop leave the count alone
      case ({push, pop})
         2'b10:   st_d.count = st_q.count + 1'b1;
         2'b01:   st_d.count = st_q.count - 1'b1;
         default: st_d.count = st_q.count;
      endcase
   end

   // pointer register
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // storage written without reset, data is qualified by count
   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[st_q.wr_ptr] <= i_in_data;
      end
   end
endmodule

// digital front end of the converter
module dilc_top
   import dilc_pkg::*;
#(
   parameter int CODE_W = `DILC_CODE_W,
   parameter int DEPTH  = `DILC_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   // parallel sample input, taken every edge while o_code_ready is high
   input  wire logic [CODE_W-1:0] i_code,
   output logic                   o_code_ready,
   // static control pins; drive low when left open
   input  wire dilc_ctrl_t        i_ctrl,
   // drain handshake from the conversion array
   input  wire logic              i_array_ready,
   // conversion array side
   output logic      [CODE_W-1:0] o_array_code,
   output logic                   o_array_valid,
   output logic                   o_code_defined,
   output logic                   o_standby,
   output logic                   o_int_ref_en,
   output logic                   o_ext_ref_in
);
   typedef struct packed {
      logic [CODE_W-1:0]         slave;     // code seen by the array
      logic                      slave_vld; // slave holds a real code
      logic [`DILC_WARMUP_W-1:0] warm;      // edges since power-up
      dilc_mode_t                mode;      // run or standby
      logic                      ext_ref;   // external reference chosen
   } dilc_st_t;

   dilc_st_t          st_q;      // registered state
   dilc_st_t          st_d;      // next state
   logic              f_valid;   // fifo has a code
   logic [CODE_W-1:0] f_data;    // fifo head
   logic              f_pop;     // slave loads from fifo

   // the fifo write is the master stage, so without a backlog capture and the slave load are
   // one edge apart; a deeper pre-stage would break the one-cycle latency
   dilc_fifo #(
      .WIDTH (CODE_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .i_in_valid  (1'b1),
      .i_in_data   (i_code),
      .o_in_ready  (o_code_ready),
      .o_out_valid (f_valid),
      .o_out_data  (f_data),
      .i_out_ready (f_pop)
   );

   // the array accepts a new code only when ready; a stall backs up the fifo
   assign f_pop = f_valid && i_array_ready;

   // next-state logic
   always_comb begin
      st_d = st_q;
      // whole word was taken into the fifo at an earlier edge, the previous one when there is no backlog
      if (f_pop) begin
         st_d.slave     = f_data;
         st_d.slave_vld = 1'b1;
      end
      // count to the warm-up limit and stay
      if (st_q.warm != `DILC_WARMUP_W'(`DILC_WARMUP_EDGES)) begin
         st_d.warm = st_q.warm + 1'b1;
      end
      // open pin reaches us as low, so run is the default
      case (i_ctrl.power_down_pin)
         1'b1:    st_d.mode = DILC_STANDBY;
         default: st_d.mode = DILC_RUN;
      endcase
      st_d.ext_ref = i_ctrl.ref_select;
   end

   // state register
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q      <= '0;
         st_q.mode <= DILC_RUN;
      end else begin
         st_q <= st_d;
      end
   end

   // code passes unchanged as unsigned binary, lsb in bit 0
   assign o_array_code   = st_q.slave;
   assign o_array_valid  = st_q.slave_vld;
   assign o_code_defined = st_q.slave_vld &&
                           (st_q.warm == `DILC_WARMUP_W'(`DILC_WARMUP_EDGES));
   assign o_standby      = (st_q.mode == DILC_STANDBY);
   // the reference mux sits in the analog core; we only steer it
   assign o_int_ref_en   = !st_q.ext_ref;
   assign o_ext_ref_in   = st_q.ext_ref;
endmodule

`default_nettype wire

// >>> tb/dilc_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// sample source: one new code per clock, counting up
module dilc_src_model
   import dilc_pkg::*;
(
   input  wire logic i_core_clk,
   output dilc_code_t o_code
);
   initial o_code = 8'h00;
   // change 1 ns after the edge so setup and hold stay clean
   always @(posedge i_core_clk) begin
      #1 o_code <= o_code + 8'h01;
   end
endmodule
`default_nettype wire

// >>> tb/dilc_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the converter front end
module dilc_top_sva
   import dilc_pkg::*;
#(parameter int CODE_W = 8, parameter int DEPTH = 8)
(
   input wire logic              i_core_clk,
   input wire logic              i_rst,
   input wire logic [CODE_W-1:0] i_code,
   input wire logic              o_code_ready,
   input wire dilc_ctrl_t        i_ctrl,
   input wire logic              i_array_ready,
   input wire logic [CODE_W-1:0] o_array_code,
   input wire logic              o_array_valid,
   input wire logic              o_code_defined,
   input wire logic              o_standby,
   input wire logic              o_int_ref_en,
   input wire logic              o_ext_ref_in
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // output must stay undefined over the first two edges
   sequence s_warm;
      !o_code_defined ##1 !o_code_defined;
   endsequence
   a_pd_standby: assert property (i_ctrl.power_down_pin |=> o_standby)
      else $error("standby not entered");
   a_pd_run: assert property (!i_ctrl.power_down_pin |=> !o_standby)
      else $error("standby while pin low");
   a_ref_ext: assert property (i_ctrl.ref_select |=> o_ext_ref_in && !o_int_ref_en)
      else $error("external reference not chosen");
   a_ref_int: assert property (!i_ctrl.ref_select |=> o_int_ref_en && !o_ext_ref_in)
      else $error("internal reference not chosen");
   a_warm_two: assert property ($fell(i_rst) |-> s_warm)
      else $error("code defined too early");
   a_def_valid: assert property (o_code_defined |-> o_array_valid)
      else $error("defined without a loaded code");
   a_valid_hold: assert property (o_array_valid |=> o_array_valid)
      else $error("valid dropped");
   a_stall_hold: assert property (!i_array_ready |=> $stable(o_array_code))
      else $error("code moved while stalled");
endmodule
bind dilc_top dilc_top_sva #(.CODE_W(CODE_W), .DEPTH(DEPTH)) u_sva (.*);
`default_nettype wire

// >>> tb/tb_dilc_top.sv
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the converter front end
module tb_dilc_top
   import dilc_pkg::*;
;
   logic       clk = 1'b0;  // 10 MHz core clock
   logic       rst = 1'b1;  // async reset
   dilc_ctrl_t ctrl = '0;   // pins tied low, as the pull-down would
   logic       rdy = 1'b0;  // array drain ready
   dilc_code_t code, acode, h0, h1, p;
   logic       crdy, aval, cdef, stby, iref, eref;
   int         error_cnt = 0;
   int         samples_checked = 0;
   int         cyc = 0;
   always #50 clk = ~clk;
   dilc_src_model u_src (.i_core_clk(clk), .o_code(code));
   dilc_top dut_u (.i_core_clk(clk), .i_rst(rst), .i_code(code), .o_code_ready(crdy),
      .i_ctrl(ctrl), .i_array_ready(rdy), .o_array_code(acode), .o_array_valid(aval),
      .o_code_defined(cdef), .o_standby(stby), .o_int_ref_en(iref), .o_ext_ref_in(eref));
   // codes seen on the pins, newest first
   always @(posedge clk) begin
      h1 <= h0;
      h0 <= code;
   end
   // hang guard: the whole run needs about 77 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // inputs move 1 ns after the edge, outputs are settled then
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic t_reset();
      rst = 1'b1;
      repeat (10) step();
      rst = 1'b0;
      check(cdef, 1'b0);
      check(iref, 1'b1);
   endtask
   // steady flow: slave shows the code captured one edge earlier
   task automatic t_stream();
      rdy = 1'b1;
      repeat (6) step();
      repeat (8) begin
         step();
         check(acode, h1);
         check(cdef, 1'b1);
      end
   endtask
   task automatic t_ctrl();
      for (int i = 0; i < 4; i++) begin
         ctrl = dilc_ctrl_t'(i[1:0]);
         step();
         step();
         check(stby, ctrl.power_down_pin);
         check(eref, ctrl.ref_select);
         check(iref, !ctrl.ref_select);
      end
      ctrl = '0;
   endtask
   // stall until the buffer refuses, then drain in order
   task automatic t_stall();
      rdy = 1'b0;
      step();
      p = acode;
      repeat (12) step();
      check(acode, p);
      check(crdy, 1'b0);
      rdy = 1'b1;
      step();
      repeat (7) begin
         p = acode;
         step();
         check(acode, p + 8'h01);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      t_reset();
      t_stream();
      t_ctrl();
      t_stall();
      t_reset();
      t_stream();
      end_of_test();
   end
endmodule
`default_nettype wire
